/* File: pcs_map.svh */
// Purpose: offsets, field positions, reset values and timing counts of the control/status bank.
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one register per aligned word.
// Notes: definitions only.
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PCS_OFF_ARITH 8'h00
`define PCS_OFF_NIB1 8'h04
`define PCS_OFF_NIB2 8'h08
`define PCS_OFF_PANEL 8'h0c
`define PCS_OFF_MEMERR 8'h10
`define PCS_OFF_BCOND 8'h14
`define PCS_OFF_MSIZE 8'h18
`define PCS_OFF_TAPE 8'h1c
`define PCS_OFF_IODATA 8'h20
`define PCS_OFF_IOCMD 8'h24
`define PCS_OFF_MODE 8'h28
`define PCS_OFF_BASE 8'h2c
`define PCS_OFF_LIMIT 8'h30
`define PCS_OFF_IRMOVE 8'h34

// ----------------------------------------
// field positions
// ----------------------------------------
`define PCS_CARRY_BIT 7
`define PCS_UNIT_BIT 5
`define PCS_LEN_MSB 4
`define PCS_LEN_LSB 0
`define PCS_BCOND_CARRY_BIT 2
`define PCS_STATE_LAMP_BIT 3
`define PCS_RTC_BIT 2
`define PCS_SRQ_BIT 1
`define PCS_PSW_BIT 0
`define PCS_MERR_BIT 3
`define PCS_OVR_BIT 2
`define PCS_OOB_RD_BIT 1
`define PCS_OOB_WR_BIT 0
`define PCS_MODE_TAPE_BIT 0
`define PCS_MODE_LOST_BIT 1
`define PCS_MODE_VALID_BIT 2

// ----------------------------------------
// synchroniser lanes
// ----------------------------------------
`define PCS_SYNC_W 6
`define PCS_SI_MAINS 0
`define PCS_SI_SEL60 1
`define PCS_SI_SRQ 2
`define PCS_SI_PSW 3
`define PCS_SI_TBIT 4
`define PCS_SI_TSTB 5

// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define PCS_BLK_RESET 4'hf
`define PCS_OE_N_RESET 1'b1
`define PCS_MSIZE_LOW_ZERO 16'h0000
`define PCS_TAPE_WORD_BITS 5'h10
`define PCS_BUS_SETTLE 2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define PCS_RESP_GAP_CLK 4'h8
`define PCS_CMD_AFTER_RESP_CLK 4'h4
`define PCS_GAP_SAT 4'hf
`define PCS_RTC_PERIOD_MS 100
`define PCS_MS_PER_S 1000
`define PCS_MAINS_50_HZ 50
`define PCS_MAINS_60_HZ 60

`endif

/* File: pcs_pkg.sv */
// Purpose: types of the control/status bank.
// Assumes: used with pcs_map.svh.
// Notes: whole module state is one packed struct.
package pcs_pkg;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_DONE,
    PH_RD_TAPE,
    PH_RESP_WR,
    PH_RESP_RD,
    PH_CAP,
    PH_CMD
  } pcs_phase_t;

  typedef struct packed {
    logic [7:0] arith;
    logic [3:0] gen1;
    logic [3:0] gen2;
    logic [3:0] pif;
    logic [3:0] mef;
    logic [3:0] blk_pif;
    logic [3:0] blk_mef;
    logic [23:0] base;
    logic [23:0] limit;
    logic tape_mode;
    logic lost;
    logic [15:0] col_sh;
    logic [4:0] col_cnt;
    logic [15:0] col_word;
    logic col_valid;
    logic [23:0] or_pend;
    logic [23:0] ir;
    logic ir_stb;
    logic [23:0] bus_out;
    logic bus_oe_n;
    logic resp_stb;
    logic cmd_stb;
    logic [3:0] since_resp;
    logic [2:0] rtc_cnt;
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] st;
    logic [23:0] b1;
    logic [23:0] b2;
    logic [23:0] b3;
    logic [1:0] cap_wait;
    pcs_phase_t phase;
    logic [31:0] rdata;
  } pcs_state_t;

endpackage

/* File: pcs_ctrl_regs.sv */
// Purpose: control register sections, flag nibbles, tape collector and I/O bus ports.
// Assumes: 200 MHz REF_CLK_I, synchronous active-high RST_I acting as panel clear.
// Notes: every bus access takes at least one wait cycle; readdata comes from a flop.
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "pcs_map.svh"

module pcs_ctrl_regs #(
  parameter logic [7:0] MEM_SIZE_UNITS = 8'h10
) (
  input wire logic REF_CLK_I, // 200 MHz clock
  input wire logic RST_I, // panel clear, sync high
  input wire logic [7:0] AVS_ADDRESS_I, // byte address
  input wire logic AVS_READ_I, // read request
  input wire logic AVS_WRITE_I, // write request
  input wire logic [31:0] AVS_WRITEDATA_I, // write data
  input wire logic [3:0] AVS_BYTEENABLE_I, // byte lanes
  output logic [31:0] AVS_READDATA_O, // read data
  output logic AVS_WAITREQUEST_O, // stall
  output logic CARRY_FLAG_O, // carry flag
  output logic UNIT_BCD_O, // 1: decimal unit
  output logic [4:0] OPERAND_LENGTH_O, // operand length
  output logic STATE_LAMP_O, // console state lamp
  output logic INT_LAMP_O, // interrupt switch lamp
  input wire logic MAINS_TICK_I, // mains-derived clock pin
  input wire logic MAINS_60HZ_I, // 1: 60 Hz mains
  input wire logic SRQ_I, // shared service request
  input wire logic PANEL_INT_SW_I, // panel interrupt switch
  input wire logic [7:0] MEM_ERR_EVENTS_I, // error event pulses
  input wire logic MEM_ACC_I, // memory access pulse
  input wire logic MEM_WR_I, // 1: write or swap
  input wire logic [23:0] FIELD_ADDRESS_I, // access address
  output logic MEM_WRITE_ALLOW_O, // write may proceed
  input wire logic TAPE_BIT_I, // cassette data bit
  input wire logic TAPE_STB_I, // cassette bit clock
  output logic [23:0] INSTR_WORD_O, // word to instruction reg
  output logic INSTR_STB_O, // instruction word pulse
  input wire logic [23:0] IO_BUS_I, // bus lines in
  output logic [23:0] IO_BUS_O, // bus lines out
  output logic IO_BUS_OE_N_O, // low while driving
  output logic RESP_STROBE_O, // response strobe
  output logic CMD_STROBE_O // command strobe
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  function automatic logic gap_ok(input logic [3:0] since, input logic [3:0] need);
    return since >= need;
  endfunction

  pcs_pkg::pcs_state_t q;
  pcs_pkg::pcs_state_t d;
  logic req;
  logic oob;

  assign oob = (FIELD_ADDRESS_I < q.base) || (FIELD_ADDRESS_I > q.limit);
  assign req = AVS_READ_I || AVS_WRITE_I;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic mains_edge;
    logic tstb_edge;
    logic word_done;
    logic lost_clr;
    logic [2:0] rtc_ticks;
    logic [3:0] set_pif;
    logic [3:0] set_mef;
    logic [15:0] new_sh;
    logic [31:0] wm;
    mains_edge = 1'b0;
    tstb_edge = 1'b0;
    word_done = 1'b0;
    lost_clr = 1'b0;
    rtc_ticks = '0;
    set_pif = '0;
    set_mef = '0;
    new_sh = '0;
    wm = '0;

    d = q;
    d.ir_stb = 1'b0;
    d.resp_stb = 1'b0;
    d.cmd_stb = 1'b0;
    d.bus_oe_n = `PCS_OE_N_RESET;
    d.blk_pif = '0;
    d.blk_mef = '0;

    // pins: three flops, accept when stages two and three agree
    d.s1 = {TAPE_STB_I, TAPE_BIT_I, PANEL_INT_SW_I, SRQ_I, MAINS_60HZ_I, MAINS_TICK_I};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < `PCS_SYNC_W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.st[i] = q.s3[i];
      end
    end
    d.b1 = IO_BUS_I;
    d.b2 = q.b1;
    d.b3 = q.b2;
    mains_edge = (q.s2[`PCS_SI_MAINS] == q.s3[`PCS_SI_MAINS]) && q.s3[`PCS_SI_MAINS] && !q.st[`PCS_SI_MAINS];
    tstb_edge = (q.s2[`PCS_SI_TSTB] == q.s3[`PCS_SI_TSTB]) && q.s3[`PCS_SI_TSTB] && !q.st[`PCS_SI_TSTB];

    if (q.since_resp != `PCS_GAP_SAT) begin
      d.since_resp = q.since_resp + 4'h1;
    end

    rtc_ticks = q.st[`PCS_SI_SEL60] ?
      3'((`PCS_RTC_PERIOD_MS * `PCS_MAINS_60_HZ) / `PCS_MS_PER_S) :
      3'((`PCS_RTC_PERIOD_MS * `PCS_MAINS_50_HZ) / `PCS_MS_PER_S);
    if (mains_edge) begin
      if (q.rtc_cnt + 3'h1 >= rtc_ticks) begin
        d.rtc_cnt = '0;
        set_pif[`PCS_RTC_BIT] = 1'b1;
      end else begin
        d.rtc_cnt = q.rtc_cnt + 3'h1;
      end
    end

    set_pif[`PCS_SRQ_BIT] = q.st[`PCS_SI_SRQ];
    set_pif[`PCS_PSW_BIT] = q.st[`PCS_SI_PSW];
    // any error event sets the error flag
    set_mef[`PCS_MERR_BIT] = |MEM_ERR_EVENTS_I;
    set_mef[`PCS_OOB_RD_BIT] = MEM_ACC_I && !MEM_WR_I && oob;
    set_mef[`PCS_OOB_WR_BIT] = MEM_ACC_I && MEM_WR_I && oob;
    // sets held off one clock after a clear
    d.pif = q.pif | (set_pif & ~q.blk_pif);
    d.mef = q.mef | (set_mef & ~q.blk_mef);
    // flags are stored; only the two lamp outputs and the write override read them

    // ----------------------------------------
    // bus access sequencer
    // ----------------------------------------
    unique case (q.phase)
      pcs_pkg::PH_IDLE: begin
        if (req) begin
          d.phase = pcs_pkg::PH_DONE;
          d.rdata = '0;
          // whole word address decoded, byte lane bits 1:0 ignored
          unique case (AVS_ADDRESS_I & ~8'h03)
            `PCS_OFF_ARITH: begin
              // carry, unit select, length in one byte
              wm = be_merge({24'h000000, q.arith}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
              if (AVS_WRITE_I) begin
                d.arith = wm[7:0];
              end
              d.rdata = {24'h000000, q.arith};
            end
            `PCS_OFF_NIB1: begin
              wm = be_merge({28'h0000000, q.gen1}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
              if (AVS_WRITE_I) begin
                d.gen1 = wm[3:0];
              end
              d.rdata = {28'h0000000, q.gen1};
            end
            `PCS_OFF_NIB2: begin
              wm = be_merge({28'h0000000, q.gen2}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
              if (AVS_WRITE_I) begin
                d.gen2 = wm[3:0];
              end
              d.rdata = {28'h0000000, q.gen2};
            end
            `PCS_OFF_PANEL: begin
              wm = be_merge({28'h0000000, q.pif}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
              // write wins, cleared bits blocked next clock
              if (AVS_WRITE_I) begin
                d.pif = wm[3:0];
                d.blk_pif = ~wm[3:0];
              end
              d.rdata = {28'h0000000, q.pif};
            end
            `PCS_OFF_MEMERR: begin
              wm = be_merge({28'h0000000, q.mef}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
              // error bit also writable by software
              if (AVS_WRITE_I) begin
                d.mef = wm[3:0];
                d.blk_mef = ~wm[3:0];
              end
              d.rdata = {28'h0000000, q.mef};
            end
            `PCS_OFF_BCOND: begin
              // carry mirror, other bits belong elsewhere
              d.rdata[`PCS_BCOND_CARRY_BIT] = q.arith[`PCS_CARRY_BIT];
            end
            `PCS_OFF_MSIZE: begin
              d.rdata = {8'h00, MEM_SIZE_UNITS, `PCS_MSIZE_LOW_ZERO};
            end
            `PCS_OFF_TAPE: begin
              // stall until a word is present
              if (AVS_READ_I) begin
                if (!q.tape_mode && q.col_valid) begin
                  d.rdata = {16'h0000, q.col_word};
                  d.col_valid = 1'b0;
                end else begin
                  d.phase = pcs_pkg::PH_RD_TAPE;
                end
              end
            end
            `PCS_OFF_IODATA: begin
              if (AVS_WRITE_I) begin
                d.bus_out = AVS_WRITEDATA_I[23:0];
                d.phase = pcs_pkg::PH_RESP_WR;
              end else begin
                d.phase = pcs_pkg::PH_RESP_RD;
              end
            end
            `PCS_OFF_IOCMD: begin
              // read is a no-operation returning zero
              if (AVS_WRITE_I) begin
                d.bus_out = AVS_WRITEDATA_I[23:0];
                d.phase = pcs_pkg::PH_CMD;
              end
            end
            `PCS_OFF_MODE: begin
              if (AVS_WRITE_I && AVS_BYTEENABLE_I[0]) begin
                d.tape_mode = AVS_WRITEDATA_I[`PCS_MODE_TAPE_BIT];
                lost_clr = AVS_WRITEDATA_I[`PCS_MODE_LOST_BIT];
              end
              d.rdata[`PCS_MODE_TAPE_BIT] = q.tape_mode;
              d.rdata[`PCS_MODE_LOST_BIT] = q.lost;
              d.rdata[`PCS_MODE_VALID_BIT] = q.col_valid;
            end
            `PCS_OFF_BASE: begin
              wm = be_merge({8'h00, q.base}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
              if (AVS_WRITE_I) begin
                d.base = wm[23:0];
              end
              d.rdata = {8'h00, q.base};
            end
            `PCS_OFF_LIMIT: begin
              wm = be_merge({8'h00, q.limit}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
              if (AVS_WRITE_I) begin
                d.limit = wm[23:0];
              end
              d.rdata = {8'h00, q.limit};
            end
            `PCS_OFF_IRMOVE: begin
              // accumulate data for the next instruction
              if (AVS_WRITE_I) begin
                d.or_pend = q.or_pend | AVS_WRITEDATA_I[23:0];
              end
              d.rdata = {8'h00, q.or_pend};
            end
            default: begin
              d.rdata = '0;
            end
          endcase
        end
      end
      pcs_pkg::PH_RD_TAPE: begin
        // run mode delivers once the collector fills
        if (!q.tape_mode && q.col_valid) begin
          d.rdata = {16'h0000, q.col_word};
          d.col_valid = 1'b0;
          d.phase = pcs_pkg::PH_DONE;
        end
      end
      pcs_pkg::PH_RESP_WR: begin
        if (gap_ok(q.since_resp, `PCS_RESP_GAP_CLK)) begin
          d.resp_stb = 1'b1;
          d.bus_oe_n = 1'b0;
          d.since_resp = 4'h1;
          d.phase = pcs_pkg::PH_DONE;
        end
      end
      pcs_pkg::PH_RESP_RD: begin
        if (gap_ok(q.since_resp, `PCS_RESP_GAP_CLK)) begin
          d.resp_stb = 1'b1;
          d.since_resp = 4'h1;
          d.cap_wait = `PCS_BUS_SETTLE;
          d.phase = pcs_pkg::PH_CAP;
        end
      end
      pcs_pkg::PH_CAP: begin
        // bus lines pass the synchroniser before capture
        if (q.cap_wait != 2'h0) begin
          d.cap_wait = q.cap_wait - 2'h1;
        end else if (q.b2 == q.b3) begin
          d.rdata = {8'h00, q.b3};
          d.phase = pcs_pkg::PH_DONE;
        end
      end
      pcs_pkg::PH_CMD: begin
        // hold command strobe off after a response
        if (gap_ok(q.since_resp, `PCS_CMD_AFTER_RESP_CLK)) begin
          d.cmd_stb = 1'b1;
          d.bus_oe_n = 1'b0;
          d.phase = pcs_pkg::PH_DONE;
        end
      end
      pcs_pkg::PH_DONE: begin
        d.phase = pcs_pkg::PH_IDLE;
      end
      default: begin
        d.phase = pcs_pkg::PH_IDLE;
      end
    endcase

    // ----------------------------------------
    // tape collector
    // ----------------------------------------
    if (lost_clr) begin
      d.lost = 1'b0;
    end
    if (tstb_edge) begin
      new_sh = {q.col_sh[14:0], q.st[`PCS_SI_TBIT]};
      d.col_sh = new_sh;
      if (q.col_cnt + 5'h01 == `PCS_TAPE_WORD_BITS) begin
        d.col_cnt = '0;
        word_done = 1'b1;
      end else begin
        d.col_cnt = q.col_cnt + 5'h01;
      end
    end
    if (word_done) begin
      if (q.tape_mode) begin
        // a waiting read takes the word, else it executes
        if (q.phase == pcs_pkg::PH_RD_TAPE) begin
          d.rdata = {16'h0000, new_sh};
          d.phase = pcs_pkg::PH_DONE;
        end else begin
          // OR pending data into the instruction
          d.ir = {8'h00, new_sh} | q.or_pend;
          d.ir_stb = 1'b1;
          d.or_pend = '0;
        end
      end else begin
        // an untaken word is overwritten and lost
        if (d.col_valid) begin
          d.lost = 1'b1;
        end
        d.col_word = new_sh;
        d.col_valid = 1'b1;
      end
    end

    if (RST_I) begin
      d = '0;
      d.phase = pcs_pkg::PH_IDLE;
      // panel clear also blocks sets for one clock
      d.blk_pif = `PCS_BLK_RESET;
      d.blk_mef = `PCS_BLK_RESET;
      d.bus_oe_n = `PCS_OE_N_RESET;
      d.since_resp = `PCS_GAP_SAT;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    q <= d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign AVS_READDATA_O = q.rdata;
  assign AVS_WAITREQUEST_O = req && (q.phase != pcs_pkg::PH_DONE);
  assign CARRY_FLAG_O = q.arith[`PCS_CARRY_BIT];
  // only bit5 steers the unit, bit6 just stored
  assign UNIT_BCD_O = q.arith[`PCS_UNIT_BIT];
  assign OPERAND_LENGTH_O = q.arith[`PCS_LEN_MSB:`PCS_LEN_LSB];
  assign STATE_LAMP_O = q.pif[`PCS_STATE_LAMP_BIT];
  assign INT_LAMP_O = q.pif[`PCS_PSW_BIT];
  // override gates the write, not the flag
  assign MEM_WRITE_ALLOW_O = !oob || q.mef[`PCS_OVR_BIT];
  assign INSTR_WORD_O = q.ir;
  assign INSTR_STB_O = q.ir_stb;
  assign IO_BUS_O = q.bus_out;
  assign IO_BUS_OE_N_O = q.bus_oe_n;
  assign RESP_STROBE_O = q.resp_stb;
  assign CMD_STROBE_O = q.cmd_stb;

endmodule

/* File: pcs_ctrl_regs_props.sv */
// Purpose: port-level checks of the control/status bank.
// Assumes: bound to pcs_ctrl_regs, one clock domain.
// Notes: all checks are disabled while RST_I is high.
`timescale 1ns/1ps
module pcs_ctrl_regs_props (
  input wire logic REF_CLK_I, // clock
  input wire logic RST_I, // sync reset
  input wire logic [7:0] AVS_ADDRESS_I, // byte address
  input wire logic AVS_READ_I, // read request
  input wire logic AVS_WRITE_I, // write request
  input wire logic [31:0] AVS_WRITEDATA_I, // write data
  input wire logic [3:0] AVS_BYTEENABLE_I, // byte lanes
  input wire logic AVS_WAITREQUEST_O, // stall
  input wire logic CARRY_FLAG_O, // carry
  input wire logic UNIT_BCD_O, // decimal unit
  input wire logic [4:0] OPERAND_LENGTH_O, // length
  input wire logic INT_LAMP_O, // switch lamp
  input wire logic PANEL_INT_SW_I, // panel switch
  input wire logic [23:0] IO_BUS_O, // bus out
  input wire logic IO_BUS_OE_N_O, // bus enable
  input wire logic RESP_STROBE_O, // response strobe
  input wire logic CMD_STROBE_O // command strobe
);
  // ----------------------------------------
  // helpers and checks
  // ----------------------------------------
  logic req;
  logic [7:0] wd_q;
  assign req = AVS_READ_I | AVS_WRITE_I;
  always_ff @(posedge REF_CLK_I) begin
    wd_q <= AVS_WRITEDATA_I[7:0];
  end
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  chk_resp_gap: assert property (RESP_STROBE_O |=> !RESP_STROBE_O [*7])
    else $error("response strobes closer than 8 clocks");
  chk_cmd_spacing: assert property (RESP_STROBE_O |-> !CMD_STROBE_O ##1 !CMD_STROBE_O [*3])
    else $error("command strobe too soon after response strobe");
  chk_lamp_switch: assert property ((PANEL_INT_SW_I && !AVS_WRITE_I) [*7] |=> INT_LAMP_O)
    else $error("switch lamp not lit while switch on");
  chk_arith_fields: assert property (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I[7:2] == 6'h00 &&
    AVS_BYTEENABLE_I[0] |=> CARRY_FLAG_O == wd_q[7] && UNIT_BCD_O == wd_q[5] && OPERAND_LENGTH_O == wd_q[4:0])
    else $error("arith byte fields not taken from write");
  chk_simple_latency: assert property ($rose(req) && AVS_ADDRESS_I < 8'h1c |->
    AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
    else $error("register access not answered in one wait cycle");
  chk_data_drive: assert property (RESP_STROBE_O && AVS_WRITE_I |->
    !IO_BUS_OE_N_O && IO_BUS_O == AVS_WRITEDATA_I[23:0])
    else $error("data write not driven with its strobe");
  chk_cmd_drive: assert property (CMD_STROBE_O |->
    AVS_WRITE_I && !IO_BUS_OE_N_O && IO_BUS_O == AVS_WRITEDATA_I[23:0])
    else $error("command strobe without driven command");
  chk_cmd_read_nop: assert property (AVS_READ_I && AVS_ADDRESS_I[7:2] == 6'h09 |->
    !CMD_STROBE_O && !RESP_STROBE_O)
    else $error("command port read caused a strobe");
  chk_data_strobe: assert property ($rose(req) && AVS_ADDRESS_I[7:2] == 6'h08 |-> ##[1:9] RESP_STROBE_O)
    else $error("data port access without response strobe");
endmodule

/* File: pcs_io_partner.sv */
// Purpose: behavioural I/O control on the processor bus.
// Assumes: bus lines have no pull; released data is shown inverted.
// Notes: logs the last data and command words it was handed.
`timescale 1ns/1ps
module pcs_io_partner (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic resp_stb_i, // response strobe
  input wire logic cmd_stb_i, // command strobe
  input wire logic bus_oe_n_i, // processor drives when low
  input wire logic [23:0] bus_out_i, // processor bus out
  input wire logic [23:0] word_i, // word offered to processor
  input wire logic srq_want_i, // raise service request
  output logic [23:0] bus_o, // bus lines to processor
  output logic srq_o, // service request level
  output logic [23:0] got_data_o, // last data received
  output logic [23:0] got_cmd_o // last command received
);
  logic [2:0] hold;
  logic rel;
  logic [23:0] last;
  assign srq_o = srq_want_i;
  assign bus_o = rel ? ~last : word_i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      hold <= 3'h0;
      rel <= 1'b0;
      got_data_o <= 24'h000000;
      got_cmd_o <= 24'h000000;
    end else begin
      last <= word_i;
      if (resp_stb_i && bus_oe_n_i) begin
        hold <= 3'h6;
      end else if (hold != 3'h0) begin
        hold <= hold - 3'h1;
      end
      if (hold == 3'h1) begin
        rel <= 1'b1;
      end else if (word_i != last) begin
        rel <= 1'b0;
      end
      if (resp_stb_i && !bus_oe_n_i) begin
        got_data_o <= bus_out_i;
      end
      if (cmd_stb_i) begin
        got_cmd_o <= bus_out_i;
      end
    end
  end
endmodule

/* File: pcs_ctrl_regs_bench.sv */
// Purpose: self-checking bench of the control/status bank.
// Assumes: Avalon-MM master tasks, partner model on the I/O bus.
// Notes: expected read values are queued by the driver, compared by a monitor.
`timescale 1ns/1ps
module pcs_ctrl_regs_bench;
  logic REF_CLK_I, RST_I, AVS_READ_I, AVS_WRITE_I, MAINS_TICK_I, MAINS_60HZ_I, SRQ_I, PANEL_INT_SW_I;
  logic MEM_ACC_I, MEM_WR_I, TAPE_BIT_I, TAPE_STB_I, AVS_WAITREQUEST_O, CARRY_FLAG_O, UNIT_BCD_O;
  logic STATE_LAMP_O, INT_LAMP_O, MEM_WRITE_ALLOW_O, INSTR_STB_O, IO_BUS_OE_N_O, RESP_STROBE_O, CMD_STROBE_O;
  logic [7:0] AVS_ADDRESS_I, MEM_ERR_EVENTS_I;
  logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O, v;
  logic [3:0] AVS_BYTEENABLE_I;
  logic [4:0] OPERAND_LENGTH_O;
  logic [23:0] FIELD_ADDRESS_I, INSTR_WORD_O, IO_BUS_I, IO_BUS_O, io_word, got_data, got_cmd;
  logic srq_want;
  logic [31:0] exp_q[$];
  integer seed, err_total, compares, i;
  localparam logic [7:0] SIZE = 8'h2a;
  pcs_ctrl_regs #(.MEM_SIZE_UNITS(SIZE)) dut (.REF_CLK_I, .RST_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I,
    .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .CARRY_FLAG_O, .UNIT_BCD_O,
    .OPERAND_LENGTH_O, .STATE_LAMP_O, .INT_LAMP_O, .MAINS_TICK_I, .MAINS_60HZ_I, .SRQ_I, .PANEL_INT_SW_I,
    .MEM_ERR_EVENTS_I, .MEM_ACC_I, .MEM_WR_I, .FIELD_ADDRESS_I, .MEM_WRITE_ALLOW_O, .TAPE_BIT_I, .TAPE_STB_I,
    .INSTR_WORD_O, .INSTR_STB_O, .IO_BUS_I, .IO_BUS_O, .IO_BUS_OE_N_O, .RESP_STROBE_O, .CMD_STROBE_O);
  pcs_io_partner u_io (.clk_i(REF_CLK_I), .rst_i(RST_I), .resp_stb_i(RESP_STROBE_O), .cmd_stb_i(CMD_STROBE_O),
    .bus_oe_n_i(IO_BUS_OE_N_O), .bus_out_i(IO_BUS_O), .word_i(io_word), .srq_want_i(srq_want),
    .bus_o(IO_BUS_I), .srq_o(SRQ_I), .got_data_o(got_data), .got_cmd_o(got_cmd));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // waitrequest is sampled at the edge, so read data is taken there too
  task automatic bus_acc(input logic [7:0] a, input logic [31:0] d, input logic wr);
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= d;
    AVS_WRITE_I <= wr;
    AVS_READ_I <= !wr;
    do @(posedge REF_CLK_I); while (AVS_WAITREQUEST_O !== 1'b0);
    AVS_WRITE_I <= 1'b0;
    AVS_READ_I <= 1'b0;
    @(posedge REF_CLK_I);
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    bus_acc(a, d, 1'b1);
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus_acc(a, 32'h0, 1'b0);
  endtask
  task automatic mains_pulse();
    MAINS_TICK_I <= 1'b1;
    repeat (10) @(posedge REF_CLK_I);
    MAINS_TICK_I <= 1'b0;
    repeat (10) @(posedge REF_CLK_I);
  endtask
  task automatic acc(input logic [23:0] a, input logic wr, input logic allow);
    MEM_ACC_I <= 1'b1;
    FIELD_ADDRESS_I <= a;
    MEM_WR_I <= wr;
    @(posedge REF_CLK_I);
    if (wr) check({31'h0, MEM_WRITE_ALLOW_O}, {31'h0, allow});
    MEM_ACC_I <= 1'b0;
    @(posedge REF_CLK_I);
  endtask
  // cassette bits go out most significant first
  task automatic tape_word(input logic [15:0] w);
    for (int b = 15; b >= 0; b--) begin
      TAPE_BIT_I <= w[b];
      repeat (3) @(posedge REF_CLK_I);
      TAPE_STB_I <= 1'b1;
      repeat (4) @(posedge REF_CLK_I);
      TAPE_STB_I <= 1'b0;
    end
  endtask
  // ----------------------------------------
  // clock, monitor, watchdog, sequence
  // ----------------------------------------
  initial begin
    REF_CLK_I = 1'b0;
    forever #2.5 REF_CLK_I = ~REF_CLK_I;
  end
  always @(posedge REF_CLK_I) begin
    if (AVS_READ_I && AVS_WAITREQUEST_O === 1'b0) check(AVS_READDATA_O, exp_q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge REF_CLK_I);
    err_total = err_total + 1;
    give_verdict();
  end
  initial begin
    {AVS_READ_I, AVS_WRITE_I, MAINS_TICK_I, MAINS_60HZ_I, PANEL_INT_SW_I, MEM_ACC_I, MEM_WR_I} = 7'h00;
    {TAPE_BIT_I, TAPE_STB_I, srq_want, AVS_ADDRESS_I, MEM_ERR_EVENTS_I} = 19'h00000;
    {AVS_WRITEDATA_I, FIELD_ADDRESS_I, io_word} = 80'h0;
    AVS_BYTEENABLE_I = 4'hf;
    seed = 33;
    err_total = 0;
    compares = 0;
    RST_I = 1'b1;
    repeat (20) @(posedge REF_CLK_I);
    RST_I <= 1'b0;
    // skips collector, data port and instruction move; 3c is unmapped
    for (i = 0; i < 16; i++) begin
      if (i != 7 && i != 8 && i != 13) bus_rd(8'(i * 4), (i == 6) ? {8'h0, SIZE, 16'h0} : 32'h0);
    end
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      bus_wr(8'h00, v);
      bus_rd(8'h00, {24'h0, v[7:0]});
      bus_rd(8'h14, {29'h0, v[7], 2'h0});
      bus_wr(8'h04, v >> 8);
      bus_rd(8'h04, {28'h0, v[11:8]});
      bus_wr(8'h08, v >> 12);
      bus_rd(8'h08, {28'h0, v[15:12]});
      bus_wr(8'h18, v);
      bus_wr(8'h3c, v);
      bus_rd(8'h18, {8'h0, SIZE, 16'h0});
    end
    bus_wr(8'h0c, 32'h8);
    check({31'h0, STATE_LAMP_O}, 32'h1);
    srq_want <= 1'b1;
    PANEL_INT_SW_I <= 1'b1;
    repeat (10) @(posedge REF_CLK_I);
    bus_rd(8'h0c, 32'hb);
    check({31'h0, INT_LAMP_O}, 32'h1);
    srq_want <= 1'b0;
    PANEL_INT_SW_I <= 1'b0;
    repeat (8) @(posedge REF_CLK_I);
    bus_wr(8'h0c, 32'h0);
    bus_rd(8'h0c, 32'h0);
    for (i = 0; i < 2; i++) begin
      MAINS_60HZ_I <= i[0];
      repeat (4 + i) mains_pulse();
      bus_rd(8'h0c, 32'h0);
      mains_pulse();
      bus_rd(8'h0c, 32'h4);
      bus_wr(8'h0c, 32'h0);
    end
    bus_wr(8'h2c, 32'h100);
    bus_wr(8'h30, 32'h200);
    acc(24'h100, 1'b1, 1'b1);
    acc(24'h201, 1'b1, 1'b0);
    acc(24'h050, 1'b0, 1'b0);
    bus_rd(8'h10, 32'h3);
    bus_wr(8'h10, 32'h4);
    acc(24'h201, 1'b1, 1'b1);
    bus_rd(8'h10, 32'h5);
    MEM_ERR_EVENTS_I <= 8'h01;
    @(posedge REF_CLK_I);
    MEM_ERR_EVENTS_I <= 8'h00;
    bus_rd(8'h10, 32'hd);
    v = $random(seed);
    bus_wr(8'h20, ~v);
    bus_wr(8'h20, v);
    check({8'h0, got_data}, {8'h0, v[23:0]});
    bus_wr(8'h24, v >> 4);
    check({8'h0, got_cmd}, {8'h0, v[27:4]});
    io_word <= ~v[23:0];
    bus_rd(8'h20, {8'h0, ~v[23:0]});
    bus_rd(8'h24, 32'h0);
    tape_word(~v[15:0]);
    tape_word(v[15:0]);
    bus_rd(8'h28, 32'h6);
    bus_rd(8'h1c, {16'h0, v[15:0]});
    bus_wr(8'h28, 32'h1);
    bus_wr(8'h34, 32'h0f0000);
    fork
      tape_word(v[31:16]);
      bus_rd(8'h1c, {16'h0, v[31:16]});
    join
    tape_word(v[15:0]);
    for (i = 0; i < 20 && INSTR_STB_O !== 1'b1; i++) @(posedge REF_CLK_I);
    check({8'h0, INSTR_WORD_O}, {16'h000f, v[15:0]});
    give_verdict();
  end
endmodule
bind pcs_ctrl_regs pcs_ctrl_regs_props u_props (.REF_CLK_I, .RST_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I,
  .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I, .AVS_WAITREQUEST_O, .CARRY_FLAG_O, .UNIT_BCD_O, .OPERAND_LENGTH_O,
  .INT_LAMP_O, .PANEL_INT_SW_I, .IO_BUS_O, .IO_BUS_OE_N_O, .RESP_STROBE_O, .CMD_STROBE_O);
